// [rtl/ocd_clock_outputs.v]
// Oscillator clock dividers, clock output pins and NMI filter, APB slave
//
// The APB register port is this design's own decision.
`include "ocd_defs.vh"

module ocd_clock_outputs
(
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [17:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire        fast_osc_tick,
   input  wire        slow_osc,
   input  wire        wdt_nmi_req,
   output reg         nmi_to_core,
   output reg         lcd_clk_tick,
   output reg         timer_clk_tick,
   input  wire        gpio_p30_out,
   input  wire        gpio_p30_oe,
   output wire        gpio_p30_in,
   input  wire        gpio_p13_out,
   input  wire        gpio_p13_oe,
   output wire        gpio_p13_in,
   input  wire        port3_bit0_in,
   output wire        port3_bit0_out,
   output wire        port3_bit0_oe,
   input  wire        port1_bit3_in,
   output wire        port1_bit3_out,
   output wire        port1_bit3_oe
);

////////////////////////////////////////////////////////////////////////////
// Functions
function [8:0] lcd_half;
   input [2:0] code;
   begin
      case (code)
         3'h0:    lcd_half = `OCD_LCD_HALF_32;
         3'h1:    lcd_half = `OCD_LCD_HALF_64;
         3'h2:    lcd_half = `OCD_LCD_HALF_128;
         3'h3:    lcd_half = `OCD_LCD_HALF_256;
         3'h4:    lcd_half = `OCD_LCD_HALF_512;
         default: lcd_half = `OCD_DIV_ZERO;
      endcase
   end
endfunction
function [8:0] pow2_half;
   input [2:0] code;
   begin
      pow2_half = (`OCD_DIV_ONE << code) - `OCD_DIV_ONE;
   end
endfunction
function hit;
   input [15:0] idx;
   input [17:0] addr;
   begin
      hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Registers
reg  [7:0] nfen_ff;
reg  [7:0] lclk_ff;
reg  [7:0] fout_ff;
reg  [7:0] t8_ff;
reg  [7:0] p1sel_ff;
reg  [7:0] p3sel_ff;
wire       wr_en  = psel & penable & pwrite;
wire       setup  = psel & ~penable;
wire       h_nfen = hit(`OCD_IDX_NFEN, paddr);
wire       h_lclk = hit(`OCD_IDX_LCLK, paddr);
wire       h_fout = hit(`OCD_IDX_FOUT, paddr);
wire       h_t8   = hit(`OCD_IDX_T8, paddr);
wire       h_p1   = hit(`OCD_IDX_P1SEL, paddr);
wire       h_p3   = hit(`OCD_IDX_P3SEL, paddr);
wire       mapped = h_nfen | h_lclk | h_fout | h_t8 | h_p1 | h_p3;
assign pready = 1'b1;
always @(posedge clock)
begin
   if (sys_rst)
   begin
      nfen_ff  <= `OCD_RST_NFEN;
      lclk_ff  <= `OCD_RST_LCLK;
      fout_ff  <= `OCD_RST_FOUT;
      t8_ff    <= `OCD_RST_T8;
      p1sel_ff <= `OCD_RST_PSEL;
      p3sel_ff <= `OCD_RST_PSEL;
   end
   else if (wr_en)
   begin
      if (h_nfen)
         nfen_ff <= pwdata[7:0] & `OCD_MSK_NFEN;
      if (h_lclk)
         lclk_ff <= pwdata[7:0] & `OCD_MSK_LCLK;
      if (h_fout)
         fout_ff <= pwdata[7:0] & `OCD_MSK_FOUT;
      if (h_t8)
         t8_ff <= pwdata[7:0] & `OCD_MSK_T8;
      if (h_p1)
         p1sel_ff <= pwdata[7:0] & `OCD_MSK_P1SEL;
      if (h_p3)
         p3sel_ff <= pwdata[7:0] & `OCD_MSK_P3SEL;
   end
end
// Read data latched in setup so it is steady for the access phase
reg [7:0] nxt_rd;
always @*
begin
   nxt_rd = 8'h00;
   if (h_nfen)
      nxt_rd = nfen_ff;
   if (h_lclk)
      nxt_rd = lclk_ff;
   if (h_fout)
      nxt_rd = fout_ff;
   if (h_t8)
      nxt_rd = t8_ff;
   if (h_p1)
      nxt_rd = p1sel_ff;
   if (h_p3)
      nxt_rd = p3sel_ff;
end
always @(posedge clock)
begin
   if (sys_rst)
   begin
      prdata  <= `OCD_WORD_ZERO;
      pslverr <= 1'b0;
   end
   else if (setup)
   begin
      prdata  <= {24'h00_0000, nxt_rd};
      pslverr <= ~mapped;
   end
end
wire       nmi_fe   = nfen_ff[`OCD_NMI_FE_BIT];
wire       lcd_en   = lclk_ff[`OCD_LCD_EN_BIT];
wire       lcd_slow = lclk_ff[`OCD_LCD_SRC_BIT];
wire [2:0] lcd_div  = lclk_ff[`OCD_LCD_DIV_HI:`OCD_LCD_DIV_LO];
wire       slow_oe  = fout_ff[`OCD_SLOW_OE_BIT];
wire       fast_oe  = fout_ff[`OCD_FAST_OE_BIT];
wire [1:0] fast_div = fout_ff[`OCD_FAST_DIV_HI:`OCD_FAST_DIV_LO];
wire       tmr_en   = t8_ff[`OCD_TMR_EN_BIT];
wire [2:0] tmr_div  = t8_ff[`OCD_TMR_DIV_HI:`OCD_TMR_DIV_LO];

////////////////////////////////////////////////////////////////////////////
// NMI noise filter
reg  [4:0] nmi_cnt_ff;
reg  [4:0] nxt_nmi_cnt;
always @*
begin
   nxt_nmi_cnt = `OCD_NMI_CNT_ZERO;
   if (wdt_nmi_req && nmi_cnt_ff != `OCD_NMI_MIN_CYC)
      nxt_nmi_cnt = nmi_cnt_ff + `OCD_NMI_CNT_ONE;
   else if (wdt_nmi_req)
      nxt_nmi_cnt = nmi_cnt_ff;
end

always @(posedge clock)
begin
   if (sys_rst)
   begin
      nmi_cnt_ff  <= `OCD_NMI_CNT_ZERO;
      nmi_to_core <= 1'b0;
   end
   else
   begin
      nmi_cnt_ff <= nxt_nmi_cnt;
      nmi_to_core <= nmi_fe ? (nxt_nmi_cnt == `OCD_NMI_MIN_CYC)
                            : wdt_nmi_req;
   end
end

////////////////////////////////////////////////////////////////////////////
// Slow oscillator sampling
reg        slow_s1_ff;
reg        slow_s2_ff;
reg        slow_s3_ff;
wire       slow_edge = slow_s2_ff ^ slow_s3_ff;
always @(posedge clock)
begin
   if (sys_rst)
   begin
      slow_s1_ff <= 1'b0;
      slow_s2_ff <= 1'b0;
      slow_s3_ff <= 1'b0;
   end
   else
   begin
      slow_s1_ff <= slow_osc;
      slow_s2_ff <= slow_s1_ff;
      slow_s3_ff <= slow_s2_ff;
   end
end

////////////////////////////////////////////////////////////////////////////
// Dividers; each toggles its level every (half + 1) oscillator edges
reg  [8:0] lcd_cnt_ff;
reg        lcd_lvl_ff;
reg  [8:0] fst_cnt_ff;
reg        fst_lvl_ff;
reg  [8:0] tmr_cnt_ff;
reg        tmr_lvl_ff;
reg        lcd_sel_d_ff;
reg        tmr_d_ff;
wire lcd_ok = (lcd_div <= `OCD_LCD_MAX_CODE);
wire fst_ok = (fast_div <= `OCD_FAST_MAX_CODE);
wire tmr_ok = (tmr_div <= `OCD_TMR_MAX_CODE);
wire lcd_sel = lcd_slow ? slow_s2_ff : (lcd_lvl_ff & lcd_ok);
always @(posedge clock)
begin
   if (sys_rst)
   begin
      lcd_cnt_ff   <= `OCD_DIV_ZERO;
      lcd_lvl_ff   <= 1'b0;
      fst_cnt_ff   <= `OCD_DIV_ZERO;
      fst_lvl_ff   <= 1'b0;
      tmr_cnt_ff   <= `OCD_DIV_ZERO;
      tmr_lvl_ff   <= 1'b0;
      lcd_sel_d_ff <= 1'b0;
      tmr_d_ff     <= 1'b0;
      lcd_clk_tick <= 1'b0;
      timer_clk_tick <= 1'b0;
   end
   else
   begin
      if (!lcd_ok)
      begin
         lcd_cnt_ff <= `OCD_DIV_ZERO;
         lcd_lvl_ff <= 1'b0;
      end
      else if (fast_osc_tick)
      begin
         if (lcd_cnt_ff >= lcd_half(lcd_div))
         begin
            lcd_cnt_ff <= `OCD_DIV_ZERO;
            lcd_lvl_ff <= ~lcd_lvl_ff;
         end
         else
            lcd_cnt_ff <= lcd_cnt_ff + `OCD_DIV_ONE;
      end
      if (!fst_ok)
      begin
         fst_cnt_ff <= `OCD_DIV_ZERO;
         fst_lvl_ff <= 1'b0;
      end
      else if (fast_osc_tick)
      begin
         if (fst_cnt_ff >= pow2_half({1'b0, fast_div}))
         begin
            fst_cnt_ff <= `OCD_DIV_ZERO;
            fst_lvl_ff <= ~fst_lvl_ff;
         end
         else
            fst_cnt_ff <= fst_cnt_ff + `OCD_DIV_ONE;
      end
      if (!tmr_ok)
      begin
         tmr_cnt_ff <= `OCD_DIV_ZERO;
         tmr_lvl_ff <= 1'b0;
      end
      else if (slow_edge)
      begin
         if (tmr_cnt_ff >= pow2_half(tmr_div))
         begin
            tmr_cnt_ff <= `OCD_DIV_ZERO;
            tmr_lvl_ff <= ~tmr_lvl_ff;
         end
         else
            tmr_cnt_ff <= tmr_cnt_ff + `OCD_DIV_ONE;
      end
      lcd_sel_d_ff <= lcd_sel;
      tmr_d_ff     <= tmr_lvl_ff;
      lcd_clk_tick <= lcd_en & lcd_sel & ~lcd_sel_d_ff;
      timer_clk_tick <= tmr_en & tmr_lvl_ff & ~tmr_d_ff;
   end
end

////////////////////////////////////////////////////////////////////////////
// Shared pins
// Enable gates the level directly, so a short pulse can appear on switching
// Output switches at once
wire fast_clk_out = fast_oe & fst_lvl_ff;
wire slow_clk_out = slow_oe & slow_s2_ff;
assign port3_bit0_out = p3sel_ff[`OCD_P3_SEL_BIT] ? fast_clk_out
                                                  : gpio_p30_out;
assign port3_bit0_oe  = p3sel_ff[`OCD_P3_SEL_BIT] | gpio_p30_oe;
assign gpio_p30_in    = port3_bit0_in;

assign port1_bit3_out = p1sel_ff[`OCD_P1_SEL_BIT] ? slow_clk_out
                                                  : gpio_p13_out;
assign port1_bit3_oe  = p1sel_ff[`OCD_P1_SEL_BIT] | gpio_p13_oe;
assign gpio_p13_in    = port1_bit3_in;

endmodule // ocd_clock_outputs

// [rtl/ocd_defs.vh]
// Register map, field layout and reset values of the clock output block
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH

// Register indices; byte address is four times the index
`define OCD_IDX_NFEN        16'h5062
`define OCD_IDX_LCLK        16'h5063
`define OCD_IDX_FOUT        16'h5064
`define OCD_IDX_T8          16'h5065
`define OCD_IDX_P1SEL       16'h52a1
`define OCD_IDX_P3SEL       16'h52a3

// Reset values
`define OCD_RST_NFEN        8'h00
`define OCD_RST_LCLK        8'h02
`define OCD_RST_FOUT        8'h00
`define OCD_RST_T8          8'h00
`define OCD_RST_PSEL        8'h00

// Writable bit masks; reserved bits read as zero
`define OCD_MSK_NFEN        8'h01
`define OCD_MSK_LCLK        8'h1f
`define OCD_MSK_FOUT        8'h0f
`define OCD_MSK_T8          8'h0f
`define OCD_MSK_P1SEL       8'h08
`define OCD_MSK_P3SEL       8'h01

// Field positions
`define OCD_NMI_FE_BIT      0
`define OCD_LCD_EN_BIT      0
`define OCD_LCD_SRC_BIT     1
`define OCD_LCD_DIV_LO      2
`define OCD_LCD_DIV_HI      4
`define OCD_SLOW_OE_BIT     0
`define OCD_FAST_OE_BIT     1
`define OCD_FAST_DIV_LO     2
`define OCD_FAST_DIV_HI     3
`define OCD_TMR_EN_BIT      0
`define OCD_TMR_DIV_LO      1
`define OCD_TMR_DIV_HI      3
`define OCD_P3_SEL_BIT      0
`define OCD_P1_SEL_BIT      3

// Noise filter length in system clock cycles
`define OCD_NMI_MIN_CYC     5'd16
`define OCD_NMI_CNT_ONE     5'd1
`define OCD_NMI_CNT_ZERO    5'd0

// Divider edge counts (half periods minus one), 9 bits
`define OCD_DIV_ZERO        9'h000
`define OCD_DIV_ONE         9'h001
`define OCD_LCD_HALF_32     9'h01f
`define OCD_LCD_HALF_64     9'h03f
`define OCD_LCD_HALF_128    9'h07f
`define OCD_LCD_HALF_256    9'h0ff
`define OCD_LCD_HALF_512    9'h1ff
`define OCD_LCD_MAX_CODE    3'h4
`define OCD_FAST_MAX_CODE   2'h2
`define OCD_TMR_MAX_CODE    3'h5

`define OCD_WORD_ZERO       32'h0000_0000

`endif

// [verification/ocd_far_side.sv]
// Far side model: external pins with pull-ups
module ocd_far_side
(
   input  wire port3_bit0_out,
   input  wire port3_bit0_oe,
   input  wire port1_bit3_out,
   input  wire port1_bit3_oe,
   output wire port3_bit0_in,
   output wire port1_bit3_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pin goes to the pull-up, never keeps the last level
   assign port3_bit0_in = port3_bit0_oe ? port3_bit0_out : 1'b1;
   assign port1_bit3_in = port1_bit3_oe ? port1_bit3_out : 1'b1;
endmodule // ocd_far_side

// [verification/ocd_props.sv]
// Port checker for the clock output block
`include "ocd_defs.vh"
module ocd_props
(
   input wire        clock,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire        wdt_nmi_req,
   input wire        nmi_to_core,
   input wire        lcd_clk_tick,
   input wire        gpio_p30_out,
   input wire        gpio_p30_oe,
   input wire        gpio_p13_out,
   input wire        gpio_p13_oe,
   input wire        port3_bit0_out,
   input wire        port3_bit0_oe,
   input wire        port1_bit3_out,
   input wire        port1_bit3_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   reg       p3s_ff, p1s_ff, fe_ff, se_ff, nf_ff, le_ff;
   reg [4:0] hc_ff;
   // Shadow of select and enable bits, taken at the write edge
   always @(posedge clock)
   begin
      if (sys_rst)
         {p3s_ff, p1s_ff, fe_ff, se_ff, nf_ff, le_ff} <= 6'h00;
      else if (psel && penable && pwrite)
         case (paddr[17:2])
            `OCD_IDX_P3SEL: p3s_ff <= pwdata[0];
            `OCD_IDX_P1SEL: p1s_ff <= pwdata[3];
            `OCD_IDX_FOUT: {fe_ff, se_ff} <= pwdata[1:0];
            `OCD_IDX_NFEN: nf_ff <= pwdata[0];
            `OCD_IDX_LCLK: le_ff <= pwdata[0];
            default: ;
         endcase
   end
   // Request run length, saturating at the filter length
   always @(posedge clock)
   begin
      if (sys_rst || !wdt_nmi_req)
         hc_ff <= 5'h00;
      else if (hc_ff != 5'h10)
         hc_ff <= hc_ff + 5'h01;
   end
////////////////////////////////////////
   default clocking dc @(posedge clock); endclocking
   default disable iff (sys_rst);
   port3_gpio_a:
      assert property (!p3s_ff |-> {port3_bit0_out, port3_bit0_oe} ==
         {gpio_p30_out, gpio_p30_oe}) else $error("port3 mux wrong");
   port1_gpio_a:
      assert property (!p1s_ff |-> {port1_bit3_out, port1_bit3_oe} ==
         {gpio_p13_out, gpio_p13_oe}) else $error("port1 mux wrong");
   fast_stop_a:
      assert property (p3s_ff && !fe_ff |-> !port3_bit0_out)
         else $error("fast pin not stopped");
   slow_stop_a:
      assert property (p1s_ff && !se_ff |-> !port1_bit3_out)
         else $error("slow pin not stopped");
   nmi_bypass_a:
      assert property (!nf_ff |=> nmi_to_core == $past(wdt_nmi_req))
         else $error("nmi bypass wrong");
   nmi_pass_a:
      assert property (nf_ff && hc_ff == 5'h0f && wdt_nmi_req
         |=> nmi_to_core) else $error("long nmi not passed");
   nmi_short_a:
      assert property (nf_ff && $past(nf_ff) && nmi_to_core
         |-> hc_ff == 5'h10) else $error("short nmi passed");
   lcd_gate_a:
      assert property (!le_ff && !$past(le_ff) && !$past(le_ff, 2)
         |-> !lcd_clk_tick) else $error("lcd clock while off");
   cover property (nf_ff && $rose(nmi_to_core));
   cover property (le_ff && lcd_clk_tick);
   cover property (p3s_ff && fe_ff && $rose(port3_bit0_out));
endmodule // ocd_props

bind ocd_clock_outputs ocd_props u_props
(
   .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .wdt_nmi_req, .nmi_to_core, .lcd_clk_tick, .gpio_p30_out,
   .gpio_p30_oe, .gpio_p13_out, .gpio_p13_oe, .port3_bit0_out,
   .port3_bit0_oe, .port1_bit3_out, .port1_bit3_oe
);

// [verification/osc_clock_dividers_and_outputs_bench.sv]
// Self-checking bench for the clock output block
`include "ocd_defs.vh"
`define CHK(nm, ex, got) \
   begin \
      num_checks++; \
      if ((got) !== (ex)) \
      begin \
         n_errors++; \
         $display("wrong value %s exp %0h got %0h", nm, ex, got); \
      end \
   end
module osc_clock_dividers_and_outputs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = '0, sys_rst = '1, psel = '0, penable = '0;
   logic        pwrite = '0, fast_osc_tick = '1, slow_osc = '0;
   logic        wdt_nmi_req = '0, gpio_p30_out = '0, gpio_p30_oe = '0;
   logic        gpio_p13_out = '0, gpio_p13_oe = '0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [2:0]  sc = '0;
   logic        tk_half = '0;
   wire  [31:0] prdata;
   wire         pready, pslverr, nmi_to_core, lcd_clk_tick, timer_clk_tick;
   wire         gpio_p30_in, gpio_p13_in, port3_bit0_in, port3_bit0_out;
   wire         port3_bit0_oe, port1_bit3_in, port1_bit3_out, port1_bit3_oe;
   wire  [3:0]  sv = {port1_bit3_out, port3_bit0_out, timer_clk_tick,
      lcd_clk_tick};
   int          n_errors = 0, num_checks = 0;

   ocd_clock_outputs DUT
   (
      .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .fast_osc_tick, .slow_osc, .wdt_nmi_req,
      .nmi_to_core, .lcd_clk_tick, .timer_clk_tick, .gpio_p30_out,
      .gpio_p30_oe, .gpio_p30_in, .gpio_p13_out, .gpio_p13_oe, .gpio_p13_in,
      .port3_bit0_in, .port3_bit0_out, .port3_bit0_oe, .port1_bit3_in,
      .port1_bit3_out, .port1_bit3_oe
   );
   ocd_far_side far
   (
      .port3_bit0_out, .port3_bit0_oe, .port1_bit3_out, .port1_bit3_oe,
      .port3_bit0_in, .port1_bit3_in
   );
   always #5 clock = ~clock;
   // Fast oscillator edge every cycle, or every other one when halved
   always @(posedge clock)
      fast_osc_tick <= tk_half ? ~fast_osc_tick : 1'b1;
   // Slow oscillator with a period of 16 system clocks
   always @(posedge clock)
   begin
      sc <= sc + 3'h1;
      if (sc == 3'h7)
         slow_osc <= ~slow_osc;
   end
////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Reads compare data and error; writes ignore both
   task automatic xf(input logic w, input logic [15:0] ix,
      input logic [7:0] d, input logic [7:0] ed, input logic ee);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (k == 50)
      begin
         n_errors++;
         close_out;
      end
      if (!w)
      begin
         `CHK("rdata", {24'h00_0000, ed}, prdata)
         `CHK("slverr", ee, pslverr)
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] ix, input logic [7:0] d);
      xf(1'b1, ix, d, 8'h00, 1'b0);
   endtask
   // Measures the gap between the second and third rise
   task automatic pc(input int s, input int ex);
      int k, t, r, p;
      logic o;
      p = 0;
      r = 0;
      t = 0;
      o = 1'b1;
      for (k = 0; k < 3500 && p == 0; k++)
      begin
         @(negedge clock);
         if (sv[s] === 1'b1 && o === 1'b0)
         begin
            if (r == 2)
               p = k - t;
            r++;
            t = k;
         end
         o = sv[s];
      end
      `CHK("period", ex, p)
      if (p == 0 && ex != 0)
         close_out;
   endtask
   task automatic t_reset;
      logic [15:0] ix [6] = '{`OCD_IDX_NFEN, `OCD_IDX_LCLK, `OCD_IDX_FOUT,
         `OCD_IDX_T8, `OCD_IDX_P1SEL, `OCD_IDX_P3SEL};
      logic [7:0] rv [6] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 6; i++)
         xf(1'b0, ix[i], 8'h00, rv[i], 1'b0);
      xf(1'b0, 16'h5066, 8'h00, 8'h00, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_pins;
      gpio_p30_out <= 1'b1;
      gpio_p30_oe <= 1'b1;
      @(negedge clock);
      `CHK("p30", 2'b11, {port3_bit0_out, port3_bit0_oe})
      `CHK("p30in", 1'b1, gpio_p30_in)
      `CHK("p13", 2'b00, {port1_bit3_out, port1_bit3_oe})
      `CHK("p13in", 1'b1, gpio_p13_in)
      wr(`OCD_IDX_P3SEL, 8'h01);
      wr(`OCD_IDX_P1SEL, 8'h08);
      @(negedge clock);
      `CHK("p3off", 1'b0, port3_bit0_out)
      `CHK("pin oe", 2'b11, {port3_bit0_oe, port1_bit3_oe})
      `CHK("pin in", 2'b00, {gpio_p30_in, gpio_p13_in})
      for (int c = 0; c < 4; c++)
      begin
         wr(`OCD_IDX_FOUT, 8'(c * 4 + 3));
         pc(2, c < 3 ? 2 << c : 0);
      end
      // Halved edge rate must double the output period
      tk_half <= 1'b1;
      wr(`OCD_IDX_FOUT, 8'h03);
      pc(2, 4);
      tk_half <= 1'b0;
      pc(3, 16);
      wr(`OCD_IDX_FOUT, 8'h00);
      pc(3, 0);
      $display("pin test done");
   endtask
   task automatic t_clk;
      for (int c = 0; c < 6; c++)
      begin
         wr(`OCD_IDX_LCLK, 8'(c * 4 + 1));
         pc(0, c < 5 ? 64 << c : 0);
      end
      wr(`OCD_IDX_LCLK, 8'h13);
      pc(0, 16);
      wr(`OCD_IDX_LCLK, 8'h12);
      xf(1'b0, `OCD_IDX_LCLK, 8'h00, 8'h12, 1'b0);
      pc(0, 0);
      for (int c = 0; c < 7; c++)
      begin
         wr(`OCD_IDX_T8, 8'(c * 2 + 1));
         pc(1, c < 6 ? 16 << c : 0);
      end
      wr(`OCD_IDX_T8, 8'h0a);
      pc(1, 0);
      $display("clock test done");
   endtask
   task automatic nm(input logic f, input int l, input logic x);
      logic hit;
      hit = 1'b0;
      wr(`OCD_IDX_NFEN, {7'h00, f});
      for (int k = 0; k < l + 4; k++)
      begin
         @(posedge clock);
         wdt_nmi_req <= k < l;
         @(negedge clock);
         hit = hit | nmi_to_core;
      end
      `CHK("nmi", x, hit)
      $display("nmi test done");
   endtask
   initial
   begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset;
      t_pins;
      t_clk;
      nm(1'b0, 1, 1'b1);
      nm(1'b1, 15, 1'b0);
      nm(1'b1, 16, 1'b1);
      close_out;
   end
endmodule // osc_clock_dividers_and_outputs_bench
